/* pmw_pkg.sv */
// Constants and carrier types for the power-mode and wake controller.
// Assumes an 8051-style SFR port and interrupt lines on ref_clk.
`default_nettype none
package pmw_pkg;
    // ------------------------------------------------------------
    // SFR map
    // ------------------------------------------------------------
    localparam logic [7:0] SFR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] SFR_PLL_CONTROL = 8'hD7;
    localparam logic [7:0] SFR_PART_ID = 8'hC2;
    localparam int POWER_CONTROL_REG_IDLE = 0;
    localparam int POWER_CONTROL_REG_PDOWN = 1;
    localparam int POWER_CONTROL_REG_SPI_WAKE = 5;
    localparam int POWER_CONTROL_REG_EXT0_WAKE = 6;
    localparam int PLL_LOCK_BIT = 6;
    localparam int PLL_OSC_POWERDOWN_BIT_BIT = 7;
    localparam logic [7:0] POWER_CONTROL_REG_RESET = 8'h00;
    localparam logic [7:0] PLL_CONTROL_REG_RESET = 8'h03;
    // Arbitrary identification value
    localparam logic [7:0] PART_ID_DEFAULT = 8'h50;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ = 40000000;
    localparam int unsigned POR_MS = 128;
    localparam int unsigned LOCK_US = 1000;
    localparam int unsigned OSC_START_MS = 150;
    localparam int unsigned POR_CYCLES = POR_MS * (REF_CLK_HZ / 1000);
    localparam int unsigned LOCK_CYCLES = LOCK_US * (REF_CLK_HZ / 1000000);
    localparam int unsigned OSC_CYCLES = OSC_START_MS * (REF_CLK_HZ / 1000);
    localparam logic [8:0] PLL_MULT = 9'h180;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_POR, MODE_NORMAL, MODE_IDLE, MODE_PDOWN} pmw_mode_t;
    typedef enum logic [1:0] {LOCK_DONE, LOCK_STOP, LOCK_OSC, LOCK_PLL} pmw_lock_t;
    typedef struct packed {
        logic port_hold;
        logic dac_hold;
        logic dac_hiz;
        logic strobe_force;
        logic strobe_level;
    } pmw_pin_ctl_t;
    typedef struct packed {
        logic interval_counter;
        logic spi;
        logic ext0;
        logic other;
    } pmw_wake_src_t;
endpackage
`default_nettype wire

/* pmw_sync.sv */
// Two-flop synchroniser for one level.
// Assumes input is asynchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module pmw_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pmw_sync
`default_nettype wire

/* pmw_delay.sv */
// Down counter: start loads a count, done pulses when it expires.
// Assumes start and load on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module pmw_delay (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [31:0] load,
    output logic busy,
    output logic done
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_busy;
    logic next_done;
    always_comb begin
        next_count = count;
        next_busy = busy;
        next_done = 1'b0;
        if (start) begin
            next_count = load;
            next_busy = 1'b1;
        end else if (busy) begin
            if (count <= 32'h0000_0001) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - 32'h0000_0001;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule // pmw_delay
`default_nettype wire

/* pmw_power_mode_wake_control.sv */
// Power-mode, wake and PLL lock tracking with its SFR registers.
// Assumes interrupt inputs are enabled requests on ref_clk; reset pin is async.
`timescale 1ns/10ps
`default_nettype none
module pmw_power_mode_wake_control #(
    parameter int unsigned POR_CYC = pmw_pkg::POR_CYCLES,
    parameter int unsigned LOCK_CYC = pmw_pkg::LOCK_CYCLES,
    parameter int unsigned OSC_CYC = pmw_pkg::OSC_CYCLES,
    parameter logic [7:0] PART_ID = pmw_pkg::PART_ID_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reset_pin_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic any_irq,
    input wire logic tic_irq,
    input wire logic spi_irq,
    input wire logic ext0_irq,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic interval_counter_clk_en,
    output logic osc_enable,
    output logic pll_enable,
    output logic [8:0] pll_mult,
    output logic pll_locked,
    output logic cpu_reset,
    output logic wake_irq,
    output pmw_pkg::pmw_wake_src_t wake_src,
    output pmw_pkg::pmw_pin_ctl_t pin_ctl
);
    // ------------------------------------------------------------
    // Inputs and timers
    // ------------------------------------------------------------
    logic pin_n_s;
    logic por_kick;
    logic por_busy;
    logic por_done;
    logic lock_start;
    logic [31:0] lock_load;
    logic lock_done;

    pmw_sync #(.RESET_VAL(1'b1)) u_pin_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(reset_pin_n),
        .sync_out(pin_n_s)
    );

    pmw_delay u_por_delay (
        .ref_clk(ref_clk),
        .srst(srst),
        .start(por_kick),
        .load(POR_CYC),
        .busy(por_busy),
        .done(por_done)
    );

    pmw_delay u_lock_delay (
        .ref_clk(ref_clk),
        .srst(srst),
        .start(lock_start),
        .load(lock_load),
        .busy(),
        .done(lock_done)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pmw_pkg::pmw_mode_t mode, next_mode;
    pmw_pkg::pmw_lock_t lock, next_lock;
    logic [7:0] power_control_reg, next_power_control_reg;
    logic [7:0] pll_control_reg, next_pll_control_reg;
    logic next_wake_irq;
    pmw_pkg::pmw_wake_src_t next_wake_src;
    logic pin_rst;
    logic osc_powerdown_bit;
    logic wr_power_control_reg;
    logic wr_pll;
    logic pd_wake;

    assign pin_rst = ~pin_n_s;
    assign osc_powerdown_bit = pll_control_reg[pmw_pkg::PLL_OSC_POWERDOWN_BIT_BIT];
    assign wr_power_control_reg = sfr_wr && (sfr_addr == pmw_pkg::SFR_POWER_CONTROL);
    assign wr_pll = sfr_wr && (sfr_addr == pmw_pkg::SFR_PLL_CONTROL);
    assign pd_wake = (tic_irq && !osc_powerdown_bit)
        || (spi_irq && power_control_reg[pmw_pkg::POWER_CONTROL_REG_SPI_WAKE])
        || (ext0_irq && power_control_reg[pmw_pkg::POWER_CONTROL_REG_EXT0_WAKE]);

    // ------------------------------------------------------------
    // Mode and lock sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        next_lock = lock;
        next_power_control_reg = power_control_reg;
        next_pll_control_reg = pll_control_reg;
        next_wake_irq = 1'b0;
        next_wake_src = '0;
        lock_start = 1'b0;
        lock_load = LOCK_CYC;
        case (mode)
            pmw_pkg::MODE_POR: begin
                if (por_done) begin
                    next_mode = pmw_pkg::MODE_NORMAL;
                end
            end
            pmw_pkg::MODE_NORMAL: begin
                if (wr_power_control_reg) begin
                    next_power_control_reg = sfr_wdata;
                    if (sfr_wdata[pmw_pkg::POWER_CONTROL_REG_PDOWN]) begin
                        next_mode = pmw_pkg::MODE_PDOWN;
                        next_lock = pmw_pkg::LOCK_STOP;
                    end else if (sfr_wdata[pmw_pkg::POWER_CONTROL_REG_IDLE]) begin
                        next_mode = pmw_pkg::MODE_IDLE;
                    end
                end
                if (wr_pll) begin
                    next_pll_control_reg = sfr_wdata;
                end
            end
            pmw_pkg::MODE_IDLE: begin
                if (any_irq) begin
                    next_mode = pmw_pkg::MODE_NORMAL;
                    next_power_control_reg[pmw_pkg::POWER_CONTROL_REG_IDLE] = 1'b0;
                    next_power_control_reg[pmw_pkg::POWER_CONTROL_REG_PDOWN] = 1'b0;
                    next_wake_irq = 1'b1;
                    next_wake_src.other = 1'b1;
                end
            end
            pmw_pkg::MODE_PDOWN: begin
                if (pd_wake || pin_rst) begin
                    next_mode = pmw_pkg::MODE_NORMAL;
                    next_power_control_reg[pmw_pkg::POWER_CONTROL_REG_IDLE] = 1'b0;
                    next_power_control_reg[pmw_pkg::POWER_CONTROL_REG_PDOWN] = 1'b0;
                    next_wake_irq = pd_wake && !pin_rst;
                    next_wake_src.interval_counter = tic_irq && !osc_powerdown_bit;
                    next_wake_src.spi = spi_irq && power_control_reg[pmw_pkg::POWER_CONTROL_REG_SPI_WAKE];
                    next_wake_src.ext0 = ext0_irq && power_control_reg[pmw_pkg::POWER_CONTROL_REG_EXT0_WAKE];
                    lock_start = 1'b1;
                    if (osc_powerdown_bit) begin
                        next_lock = pmw_pkg::LOCK_OSC;
                        lock_load = OSC_CYC;
                    end else begin
                        next_lock = pmw_pkg::LOCK_PLL;
                    end
                end
            end
            default: begin
                next_mode = pmw_pkg::MODE_NORMAL;
            end
        endcase
        case (lock)
            pmw_pkg::LOCK_OSC: begin
                if (lock_done) begin
                    next_lock = pmw_pkg::LOCK_PLL;
                    lock_start = 1'b1;
                    lock_load = LOCK_CYC;
                end
            end
            pmw_pkg::LOCK_PLL: begin
                if (lock_done) begin
                    next_lock = pmw_pkg::LOCK_DONE;
                end
            end
            default: begin
            end
        endcase
        if (pin_rst) begin
            // Reset pin restores defaults and leaves power-down
            next_power_control_reg = pmw_pkg::POWER_CONTROL_REG_RESET;
            next_pll_control_reg = pmw_pkg::PLL_CONTROL_REG_RESET;
            next_wake_src = '0;
            next_wake_irq = 1'b0;
            if (mode != pmw_pkg::MODE_POR) begin
                next_mode = pmw_pkg::MODE_NORMAL;
            end
        end
    end

    // ------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------
    logic next_core_en;
    logic next_periph_en;
    logic next_tic_en;
    logic next_osc_en;
    logic next_pll_en;
    logic next_cpu_reset;
    logic [7:0] next_rdata;
    pmw_pkg::pmw_pin_ctl_t next_pin;

    always_comb begin
        next_core_en = (next_mode == pmw_pkg::MODE_NORMAL)
            || (next_mode == pmw_pkg::MODE_POR);
        next_periph_en = (next_mode != pmw_pkg::MODE_PDOWN);
        next_osc_en = !((next_mode == pmw_pkg::MODE_PDOWN)
            && next_pll_control_reg[pmw_pkg::PLL_OSC_POWERDOWN_BIT_BIT]);
        next_tic_en = next_osc_en;
        next_pll_en = (next_mode != pmw_pkg::MODE_PDOWN)
            && (next_lock != pmw_pkg::LOCK_OSC);
        next_cpu_reset = (next_mode == pmw_pkg::MODE_POR) || pin_rst;
        next_pin = '0;
        if (next_mode == pmw_pkg::MODE_IDLE) begin
            next_pin.port_hold = 1'b1;
            next_pin.dac_hold = 1'b1;
            next_pin.strobe_force = 1'b1;
            next_pin.strobe_level = 1'b1;
        end else if (next_mode == pmw_pkg::MODE_PDOWN) begin
            next_pin.port_hold = 1'b1;
            next_pin.dac_hiz = 1'b1;
            next_pin.strobe_force = 1'b1;
            next_pin.strobe_level = 1'b0;
        end
        next_rdata = 8'h00;
        if (sfr_rd) begin
            if (sfr_addr == pmw_pkg::SFR_POWER_CONTROL) begin
                next_rdata = power_control_reg;
            end else if (sfr_addr == pmw_pkg::SFR_PLL_CONTROL) begin
                next_rdata = pll_control_reg;
                next_rdata[pmw_pkg::PLL_LOCK_BIT] = (lock == pmw_pkg::LOCK_DONE);
            end else if (sfr_addr == pmw_pkg::SFR_PART_ID) begin
                next_rdata = PART_ID;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode <= pmw_pkg::MODE_POR;
            lock <= pmw_pkg::LOCK_DONE;
            power_control_reg <= pmw_pkg::POWER_CONTROL_REG_RESET;
            pll_control_reg <= pmw_pkg::PLL_CONTROL_REG_RESET;
            por_kick <= 1'b1;
            wake_irq <= 1'b0;
            wake_src <= '0;
            core_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            interval_counter_clk_en <= 1'b1;
            osc_enable <= 1'b1;
            pll_enable <= 1'b1;
            pll_mult <= pmw_pkg::PLL_MULT;
            pll_locked <= 1'b1;
            cpu_reset <= 1'b1;
            pin_ctl <= '0;
            sfr_rdata <= 8'h00;
        end else begin
            mode <= next_mode;
            lock <= next_lock;
            power_control_reg <= next_power_control_reg;
            pll_control_reg <= next_pll_control_reg;
            por_kick <= 1'b0;
            wake_irq <= next_wake_irq;
            wake_src <= next_wake_src;
            core_clk_en <= next_core_en;
            periph_clk_en <= next_periph_en;
            interval_counter_clk_en <= next_tic_en;
            osc_enable <= next_osc_en;
            pll_enable <= next_pll_en;
            pll_mult <= pmw_pkg::PLL_MULT;
            pll_locked <= (next_lock == pmw_pkg::LOCK_DONE);
            cpu_reset <= next_cpu_reset;
            pin_ctl <= next_pin;
            sfr_rdata <= next_rdata;
        end
    end
endmodule // pmw_power_mode_wake_control
`default_nettype wire

/* pmw_check_sva.sv */
// Port assertions for the power-mode and wake controller.
// Assumes it is bound onto pmw_power_mode_wake_control, one ref_clk domain.
`timescale 1ns/10ps
`default_nettype none
module pmw_checker #(
    parameter int unsigned POR_CYC = 20,
    parameter int unsigned LOCK_CYC = 10,
    parameter int unsigned OSC_CYC = 15,
    parameter logic [7:0] PART_ID = 8'h5a
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic any_irq,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic interval_counter_clk_en,
    input wire logic osc_enable,
    input wire logic pll_enable,
    input wire logic [8:0] pll_mult,
    input wire logic pll_locked,
    input wire logic cpu_reset,
    input wire logic wake_irq,
    input wire pmw_pkg::pmw_wake_src_t wake_src,
    input wire pmw_pkg::pmw_pin_ctl_t pin_ctl
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    wire logic in_idle = !core_clk_en && periph_clk_en && !cpu_reset;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    mult_fixed_a: assert property (pll_mult == pmw_pkg::PLL_MULT) else $error("pll multiplier wrong");
    idle_pins_a: assert property (in_idle |-> pin_ctl == 5'h1b && pll_enable && osc_enable)
        else $error("idle pin or clock state wrong");
    pd_pins_a: assert property (!periph_clk_en |-> !core_clk_en && !pll_enable && !pll_locked && pin_ctl == 5'h16)
        else $error("power-down pin or clock state wrong");
    tic_osc_a: assert property ((interval_counter_clk_en == osc_enable) && (osc_enable || !periph_clk_en))
        else $error("interval counter clock wrong");
    idle_wake_a: assert property (in_idle && any_irq |=> core_clk_en && periph_clk_en) else $error("idle not left");
    wake_pulse_a: assert property (wake_irq |-> (core_clk_en && wake_src != 4'h0) ##1 !wake_irq)
        else $error("wake pulse wrong");
    src_quiet_a: assert property (!wake_irq |-> wake_src == 4'h0) else $error("wake source without pulse");
    tic_wake_a: assert property (wake_irq && wake_src.interval_counter |-> $past(osc_enable)) else $error("tic wake, osc off");
    lock_wait_a: assert property ($rose(pll_enable) |-> !pll_locked [*8]) else $error("lock flag too early");
    id_read_a: assert property (sfr_rd && sfr_addr == pmw_pkg::SFR_PART_ID |=> sfr_rdata == PART_ID)
        else $error("part id read wrong");
    por_hold_a: assert property ($fell(srst) |-> cpu_reset [*8]) else $error("core left reset too early");
    cover property (in_idle ##1 wake_irq);
    cover property (wake_irq && wake_src.spi);
    cover property (wake_irq && wake_src.interval_counter);
    cover property ($rose(pll_locked));
endmodule // pmw_checker
bind pmw_power_mode_wake_control pmw_checker #(.POR_CYC(POR_CYC), .LOCK_CYC(LOCK_CYC), .OSC_CYC(OSC_CYC),
    .PART_ID(PART_ID)) pmw_checker_inst (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .any_irq(any_irq), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .interval_counter_clk_en(interval_counter_clk_en), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .pll_mult(pll_mult), .pll_locked(pll_locked), .cpu_reset(cpu_reset), .wake_irq(wake_irq),
    .wake_src(wake_src), .pin_ctl(pin_ctl));
`default_nettype wire

/* pmw_tb.sv */
// Self-checking bench for the power-mode and wake controller.
// Assumes short delay parameters; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int unsigned POR_C = 20;
    localparam int unsigned LOCK_C = 10;
    localparam int unsigned OSC_C = 15;
    // Arbitrary identification value
    localparam logic [7:0] ID_VAL = 8'h5a;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [3:0] irq_v = 4'h0;
    logic [7:0] sfr_rdata;
    logic [7:0] rd;
    logic core_clk_en, periph_clk_en, interval_counter_clk_en, osc_enable, pll_enable, pll_locked;
    logic cpu_reset, wake_irq;
    logic [8:0] pll_mult;
    pmw_pkg::pmw_wake_src_t wake_src;
    pmw_pkg::pmw_pin_ctl_t pin_ctl;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    pmw_power_mode_wake_control #(.POR_CYC(POR_C), .LOCK_CYC(LOCK_C), .OSC_CYC(OSC_C), .PART_ID(ID_VAL))
        pmw_power_mode_wake_control_inst (.ref_clk(ref_clk), .srst(srst), .reset_pin_n(reset_pin_n),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .any_irq(irq_v[0]), .tic_irq(irq_v[3]), .spi_irq(irq_v[2]), .ext0_irq(irq_v[1]),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .interval_counter_clk_en(interval_counter_clk_en),
        .osc_enable(osc_enable), .pll_enable(pll_enable), .pll_mult(pll_mult), .pll_locked(pll_locked),
        .cpu_reset(cpu_reset), .wake_irq(wake_irq), .wake_src(wake_src), .pin_ctl(pin_ctl));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic report_and_stop;
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask
    // Mode word: core, periph, pll enables then pin control
    task automatic chk_mode(input logic [7:0] exp);
        chk({core_clk_en, periph_clk_en, pll_enable, pin_ctl}, exp);
    endtask
    task automatic wake(input logic [3:0] v, input logic yes);
        logic seen;
        logic [3:0] src;
        seen = 1'b0;
        src = 4'h0;
        @(negedge ref_clk);
        irq_v = v;
        repeat (4) begin
            @(negedge ref_clk);
            if (wake_irq === 1'b1) begin
                seen = 1'b1;
                src = wake_src;
            end
        end
        irq_v = 4'h0;
        chk(seen, yes);
        if (yes) begin
            chk(src, v);
        end
    endtask
    task automatic wait_flag(input logic want_lock, input int lo, input int hi);
        int n;
        n = 0;
        while ((want_lock ? pll_locked !== 1'b1 : cpu_reset !== 1'b0) && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        sfr_read(pmw_pkg::SFR_POWER_CONTROL, 8'h00);
        sfr_read(pmw_pkg::SFR_PLL_CONTROL, 8'h43);
        sfr_read(pmw_pkg::SFR_PART_ID, ID_VAL);
        sfr_write(pmw_pkg::SFR_PART_ID, 8'hff);
        sfr_read(pmw_pkg::SFR_PART_ID, ID_VAL);
        sfr_read(8'h00, 8'h00);
    endtask
    task automatic t_idle;
        sfr_write(pmw_pkg::SFR_POWER_CONTROL, 8'h01);
        chk_mode(8'h7b);
        chk(osc_enable & periph_clk_en, 1);
        wake(4'h1, 1'b1);
        chk_mode(8'he0);
        sfr_read(pmw_pkg::SFR_POWER_CONTROL, 8'h00);
    endtask
    task automatic t_spi;
        sfr_write(pmw_pkg::SFR_POWER_CONTROL, 8'h22);
        chk_mode(8'h16);
        chk(pll_locked, 0);
        wake(4'h4, 1'b1);
        wait_flag(1'b1, 4, 10);
        chk_mode(8'he0);
        sfr_read(pmw_pkg::SFR_POWER_CONTROL, 8'h20);
        sfr_read(pmw_pkg::SFR_PLL_CONTROL, 8'h43);
    endtask
    task automatic t_ext0;
        sfr_write(pmw_pkg::SFR_POWER_CONTROL, 8'h42);
        wake(4'h4, 1'b0);
        wake(4'h2, 1'b1);
        wait_flag(1'b1, 0, 12);
    endtask
    task automatic t_osc;
        sfr_write(pmw_pkg::SFR_PLL_CONTROL, 8'h83);
        sfr_write(pmw_pkg::SFR_POWER_CONTROL, 8'h02);
        chk({osc_enable, interval_counter_clk_en, periph_clk_en}, 0);
        wake(4'h8, 1'b0);
        @(negedge ref_clk);
        reset_pin_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk(cpu_reset, 1);
        reset_pin_n = 1'b1;
        wait_flag(1'b1, 15, 28);
        wait_flag(1'b0, 0, 10);
        sfr_read(pmw_pkg::SFR_POWER_CONTROL, 8'h00);
        sfr_read(pmw_pkg::SFR_PLL_CONTROL, 8'h43);
    endtask
    task automatic t_tic;
        sfr_write(pmw_pkg::SFR_POWER_CONTROL, 8'h02);
        chk({osc_enable, interval_counter_clk_en, core_clk_en}, 6);
        wake(4'h8, 1'b1);
        wait_flag(1'b1, 0, 12);
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        chk({cpu_reset, pll_locked, pll_mult}, 11'h780);
        srst = 1'b0;
        wait_flag(1'b0, POR_C, POR_C + 4);
        t_regs();
        t_idle();
        t_spi();
        t_ext0();
        t_osc();
        t_tic();
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
